// [design/lclc_pkg.sv]
package lclc_pkg;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam logic [REG_AW-1:0] ADDR_LOOP = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_PATTERN_DETECT = 4'h1;
  localparam logic [REG_AW-1:0] ADDR_FIRST_STATUS = 4'h2;

  // loop register field positions
  localparam int LOOP_ANALOG_BIT = 0;
  localparam int LOOP_REMOTE_BIT = 1;
  localparam int LOOP_DIGITAL_BIT = 2;
  localparam int LOOP_AUTO_BIT = 3;
  localparam int LOOP_W = 4;
  localparam logic [LOOP_W-1:0] LOOP_RESET = 4'h0;

  // pattern detect register field positions
  localparam int PD_PLACEMENT_BIT = 3;
  localparam logic PD_PLACEMENT_RESET = 1'b0;
  localparam logic PLACE_RECEIVE = 1'b0;
  localparam logic PLACE_TRANSMIT = 1'b1;

  // first status register field positions
  localparam int STAT_AUTO_BIT = 7;
  localparam int STAT_ANALOG_BIT = 0;
  localparam int STAT_REMOTE_BIT = 1;
  localparam int STAT_DIGITAL_BIT = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam real SYS_CLK_HZ = 125000000.0;
  localparam real PERSIST_TIME_S = 5.1;
  localparam int TIMER_W = 30;
  localparam logic [TIMER_W-1:0] PERSIST_CYCLES = TIMER_W'(longint'($ceil(PERSIST_TIME_S * SYS_CLK_HZ)));

  // ---------------------------------------------------------------
  // synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int SYNC_W = 11;
  localparam int SY_LINE_CLK = 0;
  localparam int SY_RX_LINE = 1;
  localparam int SY_RX_JA = 2;
  localparam int SY_TX_SYS = 3;
  localparam int SY_TX_JA = 4;
  localparam int SY_RX_PAT = 5;
  localparam int SY_TX_PAT = 6;
  localparam int SY_RX_ACT = 7;
  localparam int SY_RX_DEACT = 8;
  localparam int SY_TX_ACT = 9;
  localparam int SY_TX_DEACT = 10;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h000;

  // alarm indication signal is all ones
  localparam logic AIS_BIT = 1'b1;

  // automatic loopback state, gray along off -> on
  typedef enum logic [1:0]
  {
    AUTO_OFF = 2'b00,
    AUTO_ON = 2'b01
  } lclc_auto_e;

endpackage

// [design/lclc_sync.sv]
module lclc_sync
  import lclc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  typedef struct packed
  {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } lclc_sync_s;

  lclc_sync_s st_q;
  lclc_sync_s st_d;

  // two flops per bit, first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_bit
      always_comb
      begin
        st_d.meta[gi] = async_in[gi];
        st_d.stable[gi] = st_q.meta[gi];
      end
    end
  endgenerate

  // register stage
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= {SYNC_RESET, SYNC_RESET};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule

// [design/lclc_persist_timer.sv]
module lclc_persist_timer
  import lclc_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LIMIT = PERSIST_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic condition,
  output logic expired
);

  typedef struct packed
  {
    logic [TIMER_W-1:0] count;
  } lclc_timer_s;

  lclc_timer_s st_q;
  lclc_timer_s st_d;

  // count while the condition holds, saturate at the limit, restart on a gap
  always_comb
  begin
    st_d = st_q;
    if (!condition)
    begin
      st_d.count = '0;
    end
    else if (st_q.count != LIMIT)
    begin
      st_d.count = st_q.count + TIMER_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // held for more than the limit
  assign expired = condition && (st_q.count == LIMIT);

endmodule

// [design/lclc_top.sv]
// Contract
// - analog loop bit b0 loops the outgoing line stream into the receive input
// - in analog loop the line keeps being driven; line receive data replaced
// - analog loop forces remote and digital loopback off
// - analog loop: rx pattern beats looped data; AIS generation off both paths
// - manual remote bit b1 enables remote loopback
// - auto remote armed only with receive placement and auto enable b3 set
// - auto remote enters after activate code over 5.1 s, leaves on deactivate
// - clearing auto enable ends an automatic loopback at once
// - status b7 shows automatic loopback active
// - remote loop: jitter attenuated rx data feeds shaper; system input ignored
// - remote loop: transmit detectors keep watching system input
// - remote loop: rx pattern beats AIS; tx pattern beats looped; tx AIS off
// - manual digital bit b2 enables digital loopback
// - transmit placement plus auto enable: digital loop by 5.1 s codes
// - digital loop: tx attenuator output to decoder; line still monitored for alarms
// - digital loop: rx pattern over loop; tx pattern over data; AIS off both paths
// - dual is manual remote with any digital; no auto remote under digital
// - dual: line data to shaper only, system data to decoder only
// - dual: rx error detectors watch looped data, alarm detectors watch line
// - manual dual: rx pattern over loop, remote loop over tx pattern, AIS off
// - auto digital dual: rx pattern over loop; AIS and tx pattern off
module lclc_top
  import lclc_pkg::*;
#(
  parameter logic [TIMER_W-1:0] PERSIST_LIMIT = PERSIST_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [REG_DW-1:0] reg_rdata,
  // line clock and streams, all asynchronous
  input wire logic line_clk,
  input wire logic rx_line_data,
  input wire logic rx_jitter_data,
  input wire logic tx_system_data,
  input wire logic tx_jitter_data,
  input wire logic rx_pattern_bit,
  input wire logic tx_pattern_bit,
  input wire logic rx_activate_code,
  input wire logic rx_deactivate_code,
  input wire logic tx_activate_code,
  input wire logic tx_deactivate_code,
  // generator enables from local logic
  input wire logic rx_pattern_enable,
  input wire logic tx_pattern_enable,
  input wire logic rx_ais_enable,
  input wire logic tx_ais_enable,
  // data paths
  output logic tx_shaper_data,
  output logic tx_line_drive_enable,
  output logic rx_decoder_data,
  output logic rx_error_detect_data,
  output logic rx_alarm_detect_data,
  output logic tx_detect_data,
  output logic tx_clock_ignored,
  // mode view
  output logic analog_loop_active,
  output logic remote_loop_active,
  output logic digital_loop_active,
  output logic automatic_loop_status
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [LOOP_W-1:0] loop;
    logic placement;
    lclc_auto_e auto_st;
    logic auto_kind;
    logic line_clk_prev;
    logic analog;
    logic remote;
    logic digital;
    logic tx_shaper;
    logic rx_decoder;
    logic rx_err_det;
    logic rx_alarm_det;
    logic tx_det;
    logic [REG_DW-1:0] rdata;
  } lclc_state_s;

  lclc_state_s st_q;
  lclc_state_s st_d;

  logic [SYNC_W-1:0] async_bus;
  logic [SYNC_W-1:0] sy;
  logic act_seen;
  logic deact_seen;
  logic act_cond;
  logic deact_cond;
  logic act_fired;
  logic deact_fired;
  logic auto_en;
  logic armed;

  // address match shared by write and read decode
  function automatic logic addr_hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] target);
    addr_hit = (a == target);
  endfunction

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  always_comb
  begin
    async_bus = '0;
    async_bus[SY_LINE_CLK] = line_clk;
    async_bus[SY_RX_LINE] = rx_line_data;
    async_bus[SY_RX_JA] = rx_jitter_data;
    async_bus[SY_TX_SYS] = tx_system_data;
    async_bus[SY_TX_JA] = tx_jitter_data;
    async_bus[SY_RX_PAT] = rx_pattern_bit;
    async_bus[SY_TX_PAT] = tx_pattern_bit;
    async_bus[SY_RX_ACT] = rx_activate_code;
    async_bus[SY_RX_DEACT] = rx_deactivate_code;
    async_bus[SY_TX_ACT] = tx_activate_code;
    async_bus[SY_TX_DEACT] = tx_deactivate_code;
  end

  lclc_sync u_sync
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(async_bus),
    .sync_out(sy)
  );

  // ---------------------------------------------------------------
  // inband code persistence
  // ---------------------------------------------------------------
  // code source follows detector placement
  always_comb
  begin
    auto_en = st_q.loop[LOOP_AUTO_BIT];
    act_seen = (st_q.placement == PLACE_TRANSMIT) ? sy[SY_TX_ACT] : sy[SY_RX_ACT];
    deact_seen = (st_q.placement == PLACE_TRANSMIT) ? sy[SY_TX_DEACT] : sy[SY_RX_DEACT];
    // receive placement also needs the manual digital loop off; transmit placement always armed
    armed = auto_en && ((st_q.placement == PLACE_TRANSMIT) || !st_q.loop[LOOP_DIGITAL_BIT]);
    act_cond = armed && (st_q.auto_st == AUTO_OFF) && act_seen;
    deact_cond = auto_en && (st_q.auto_st == AUTO_ON) && deact_seen;
  end

  lclc_persist_timer #(.LIMIT(PERSIST_LIMIT)) u_act_timer
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .condition(act_cond),
    .expired(act_fired)
  );

  lclc_persist_timer #(.LIMIT(PERSIST_LIMIT)) u_deact_timer
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .condition(deact_cond),
    .expired(deact_fired)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic line_edge;
    logic nx_analog;
    logic nx_remote;
    logic nx_digital;
    logic auto_remote;
    logic auto_digital;
    logic looped_src;
    logic tx_bit;
    logic rx_bit;
    logic rx_ais_ok;
    line_edge = 1'b0;
    nx_analog = 1'b0;
    nx_remote = 1'b0;
    nx_digital = 1'b0;
    auto_remote = 1'b0;
    auto_digital = 1'b0;
    looped_src = 1'b0;
    tx_bit = 1'b0;
    rx_bit = 1'b0;
    rx_ais_ok = 1'b0;
    st_d = st_q;

    // register writes
    if (reg_write && addr_hit(reg_addr, ADDR_LOOP))
    begin
      st_d.loop = reg_wdata[LOOP_W-1:0];
    end
    if (reg_write && addr_hit(reg_addr, ADDR_PATTERN_DETECT))
    begin
      st_d.placement = reg_wdata[PD_PLACEMENT_BIT];
    end

    // automatic loopback sequencing
    case (st_q.auto_st)
      AUTO_OFF:
      begin
        if (act_fired)
        begin
          st_d.auto_st = AUTO_ON;
          st_d.auto_kind = st_q.placement;
        end
      end
      AUTO_ON:
      begin
        if (deact_fired)
        begin
          st_d.auto_st = AUTO_OFF;
        end
        if ((st_q.auto_kind == PLACE_RECEIVE) && st_q.loop[LOOP_DIGITAL_BIT])
        begin
          st_d.auto_st = AUTO_OFF;
        end
      end
      default:
      begin
        st_d.auto_st = AUTO_OFF;
      end
    endcase
    // auto enable cleared, by write or already low, ends it at once
    if (!st_d.loop[LOOP_AUTO_BIT])
    begin
      st_d.auto_st = AUTO_OFF;
    end

    // effective modes
    auto_remote = (st_q.auto_st == AUTO_ON) && (st_q.auto_kind == PLACE_RECEIVE);
    auto_digital = (st_q.auto_st == AUTO_ON) && (st_q.auto_kind == PLACE_TRANSMIT);
    nx_analog = st_q.loop[LOOP_ANALOG_BIT];
    nx_remote = !nx_analog && (st_q.loop[LOOP_REMOTE_BIT] || auto_remote);
    nx_digital = !nx_analog && (st_q.loop[LOOP_DIGITAL_BIT] || auto_digital);

    // transmit path toward the waveform shaper
    if (nx_remote && nx_digital)
    begin
      tx_bit = sy[SY_RX_JA];
    end
    else if (nx_remote)
    begin
      tx_bit = tx_pattern_enable ? sy[SY_TX_PAT] : sy[SY_RX_JA];
    end
    else if (nx_digital || nx_analog)
    begin
      tx_bit = tx_pattern_enable ? sy[SY_TX_PAT] : sy[SY_TX_JA];
    end
    else if (tx_pattern_enable)
    begin
      tx_bit = sy[SY_TX_PAT];
    end
    else if (tx_ais_enable)
    begin
      tx_bit = AIS_BIT;
    end
    else
    begin
      tx_bit = sy[SY_TX_JA];
    end

    // receive path source toward the decoder
    if (nx_analog)
    begin
      looped_src = st_q.tx_shaper;
    end
    else if (nx_digital)
    begin
      looped_src = sy[SY_TX_JA];
    end
    else
    begin
      looped_src = sy[SY_RX_LINE];
    end
    rx_ais_ok = !nx_analog && !nx_digital;
    if (rx_pattern_enable)
    begin
      rx_bit = sy[SY_RX_PAT];
    end
    else if (rx_ais_ok && rx_ais_enable)
    begin
      rx_bit = AIS_BIT;
    end
    else
    begin
      rx_bit = looped_src;
    end

    // everything on the streams moves only on a line clock rising edge
    st_d.line_clk_prev = sy[SY_LINE_CLK];
    line_edge = sy[SY_LINE_CLK] && !st_q.line_clk_prev;
    if (line_edge)
    begin
      st_d.analog = nx_analog;
      st_d.remote = nx_remote;
      st_d.digital = nx_digital;
      st_d.tx_shaper = tx_bit;
      st_d.rx_decoder = rx_bit;
      st_d.rx_err_det = looped_src;
      st_d.rx_alarm_det = nx_analog ? st_q.tx_shaper : sy[SY_RX_LINE];
      st_d.tx_det = sy[SY_TX_SYS];
    end

    // read data stand in the cycle after the strobe only
    st_d.rdata = '0;
    if (reg_read && addr_hit(reg_addr, ADDR_LOOP))
    begin
      st_d.rdata[LOOP_W-1:0] = st_q.loop;
    end
    else if (reg_read && addr_hit(reg_addr, ADDR_PATTERN_DETECT))
    begin
      st_d.rdata[PD_PLACEMENT_BIT] = st_q.placement;
    end
    else if (reg_read && addr_hit(reg_addr, ADDR_FIRST_STATUS))
    begin
      st_d.rdata[STAT_AUTO_BIT] = (st_q.auto_st == AUTO_ON);
      st_d.rdata[STAT_ANALOG_BIT] = st_q.analog;
      st_d.rdata[STAT_REMOTE_BIT] = st_q.remote;
      st_d.rdata[STAT_DIGITAL_BIT] = st_q.digital;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '{loop: LOOP_RESET, placement: PD_PLACEMENT_RESET, auto_st: AUTO_OFF, auto_kind: PLACE_RECEIVE,
                default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the line is driven in every mode, analog loop included
  assign tx_line_drive_enable = 1'b1;
  assign tx_shaper_data = st_q.tx_shaper;
  assign rx_decoder_data = st_q.rx_decoder;
  assign rx_error_detect_data = st_q.rx_err_det;
  assign rx_alarm_detect_data = st_q.rx_alarm_det;
  assign tx_detect_data = st_q.tx_det;
  assign tx_clock_ignored = st_q.remote;
  assign analog_loop_active = st_q.analog;
  assign remote_loop_active = st_q.remote;
  assign digital_loop_active = st_q.digital;
  assign automatic_loop_status = (st_q.auto_st == AUTO_ON);
  assign reg_rdata = st_q.rdata;

endmodule

// [tb/lclc_top_sva.sv]
module lclc_top_sva
  import lclc_pkg::*;
#(
  parameter logic [TIMER_W-1:0] PERSIST_LIMIT = PERSIST_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [REG_DW-1:0] reg_rdata,
  input wire logic line_clk,
  input wire logic rx_activate_code,
  input wire logic tx_activate_code,
  input wire logic tx_shaper_data,
  input wire logic tx_line_drive_enable,
  input wire logic rx_decoder_data,
  input wire logic tx_clock_ignored,
  input wire logic analog_loop_active,
  input wire logic remote_loop_active,
  input wire logic digital_loop_active,
  input wire logic automatic_loop_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // line edge age
  // --------
  logic [1:0] smp_q;
  logic [3:0] age_q;
  // cycles since a line clock rise was sampled, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      smp_q <= 2'h0;
      age_q <= 4'hf;
    end
    else
    begin
      smp_q <= {smp_q[0], line_clk};
      age_q <= (smp_q == 2'h1) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // --------
  // properties
  // --------
  property p_drive_on;
    tx_line_drive_enable;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("line drive dropped");
  property p_clk_ignored;
    tx_clock_ignored == remote_loop_active;
  endproperty
  a_clk_ignored: assert property (p_clk_ignored)
    else $error("transmit clock ignore differs from remote loop");
  property p_analog_alone;
    analog_loop_active |-> !remote_loop_active && !digital_loop_active;
  endproperty
  a_analog_alone: assert property (p_analog_alone)
    else $error("other loop active beside analog");
  property p_shaper_edge;
    $changed(tx_shaper_data) |-> age_q <= 4'h6;
  endproperty
  a_shaper_edge: assert property (p_shaper_edge)
    else $error("shaper data moved away from a line edge");
  property p_decoder_edge;
    age_q > 4'h6 |-> $stable(rx_decoder_data);
  endproperty
  a_decoder_edge: assert property (p_decoder_edge)
    else $error("decoder data moved away from a line edge");
  property p_mode_edge;
    !$stable({analog_loop_active, remote_loop_active, digital_loop_active}) |-> age_q <= 4'h6;
  endproperty
  a_mode_edge: assert property (p_mode_edge)
    else $error("loop mode moved away from a line edge");
  property p_status_read;
    reg_read && reg_addr == ADDR_FIRST_STATUS |=> reg_rdata[STAT_AUTO_BIT] == $past(automatic_loop_status);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status auto bit wrong");
  property p_auto_drop;
    reg_write && reg_addr == ADDR_LOOP && !reg_wdata[LOOP_AUTO_BIT] |=> !automatic_loop_status;
  endproperty
  a_auto_drop: assert property (p_auto_drop)
    else $error("automatic loop kept after enable cleared");
  property p_auto_cause;
    $rose(automatic_loop_status) |-> $past(rx_activate_code | tx_activate_code, 8);
  endproperty
  a_auto_cause: assert property (p_auto_cause)
    else $error("automatic loop entered without a held code");
endmodule

bind lclc_top lclc_top_sva #(.PERSIST_LIMIT(PERSIST_LIMIT)) u_sva
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .line_clk(line_clk),
  .rx_activate_code(rx_activate_code),
  .tx_activate_code(tx_activate_code),
  .tx_shaper_data(tx_shaper_data),
  .tx_line_drive_enable(tx_line_drive_enable),
  .rx_decoder_data(rx_decoder_data),
  .tx_clock_ignored(tx_clock_ignored),
  .analog_loop_active(analog_loop_active),
  .remote_loop_active(remote_loop_active),
  .digital_loop_active(digital_loop_active),
  .automatic_loop_status(automatic_loop_status)
);

// [tb/lclc_framer_model.sv]
module lclc_framer_model
(
  input wire logic line_clk,
  input wire logic send_bit,
  input wire logic rx_decoder_data,
  output logic tx_system_data,
  output logic rx_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // system side framer
  // --------
  // launch on the falling line edge so the bit is settled at the rise
  always @(negedge line_clk)
  begin
    tx_system_data <= send_bit;
  end
  // take the decoded stream at the rise, as the framer would
  always @(posedge line_clk)
  begin
    rx_seen <= rx_decoder_data;
  end
endmodule

// [tb/lclc_top_test.sv]
module lclc_top_test import lclc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [TIMER_W-1:0] LIMIT = 30'h14;
  int fails = 0;
  int n_checks = 0;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic line_clk = 1'b0;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [REG_DW-1:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic send_bit = 1'b0;
  logic rx_line_data = 1'b0, rx_jitter_data = 1'b0, tx_jitter_data = 1'b0;
  logic rx_pattern_bit = 1'b0, tx_pattern_bit = 1'b0;
  logic rx_activate_code = 1'b0, rx_deactivate_code = 1'b0;
  logic tx_activate_code = 1'b0, tx_deactivate_code = 1'b0;
  logic rx_pattern_enable = 1'b0, tx_pattern_enable = 1'b0, rx_ais_enable = 1'b0, tx_ais_enable = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic tx_system_data, rx_seen, tx_shaper_data, tx_line_drive_enable, rx_decoder_data;
  logic rx_error_detect_data, rx_alarm_detect_data, tx_detect_data, tx_clock_ignored;
  logic analog_loop_active, remote_loop_active, digital_loop_active, automatic_loop_status;
  // --------
  // clocks, design and framer
  // --------
  always #4 sys_clk = ~sys_clk;
  always #40 line_clk = ~line_clk;
  lclc_top #(.PERSIST_LIMIT(LIMIT)) dut
  (
    .*
  );
  lclc_framer_model framer
  (
    .line_clk(line_clk),
    .send_bit(send_bit),
    .rx_decoder_data(rx_decoder_data),
    .tx_system_data(tx_system_data),
    .rx_seen(rx_seen)
  );
  // --------
  // helpers
  // --------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk("register", exp, reg_rdata);
    @(posedge sys_clk);
  endtask
  // mode, data {sys, line, rx ja, tx ja, rx pat, tx pat}, enables, paths, modes
  task automatic paths(input logic [3:0] m, input logic [5:0] d, input logic [3:0] e, input logic [4:0] x,
                       input logic [3:0] xm);
    wr(ADDR_LOOP, {4'h0, m});
    {send_bit, rx_line_data, rx_jitter_data, tx_jitter_data, rx_pattern_bit, tx_pattern_bit} <= d;
    {rx_pattern_enable, tx_pattern_enable, rx_ais_enable, tx_ais_enable} <= e;
    repeat (80) @(posedge sys_clk);
    #1;
    chk("paths", {2'h0, x, x[3]}, {2'h0, tx_shaper_data, rx_decoder_data, rx_error_detect_data,
        rx_alarm_detect_data, tx_detect_data, rx_seen});
    chk("modes", {4'h0, xm}, {4'h0, analog_loop_active, remote_loop_active, digital_loop_active, tx_clock_ignored});
    @(posedge sys_clk);
  endtask
  // hold codes until the automatic status reaches x, timing the wait
  task automatic code_run(input logic [3:0] c, input logic x);
    int n;
    n = 0;
    {rx_activate_code, rx_deactivate_code, tx_activate_code, tx_deactivate_code} <= c;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (automatic_loop_status !== x && n < 100);
    chk("auto", {7'h0, x}, {7'h0, automatic_loop_status});
    chk("persist", 8'h01, {7'h0, (n > LIMIT) && (n < LIMIT + 12)});
    @(posedge sys_clk);
  endtask
  // activate code held with loop value m must not start automatic loop
  task automatic no_auto(input logic [3:0] m);
    wr(ADDR_LOOP, {4'h0, m});
    rx_activate_code <= 1'b1;
    repeat (60) @(posedge sys_clk);
    #1;
    chk("no auto", 8'h00, {7'h0, automatic_loop_status});
    @(posedge sys_clk);
    rx_activate_code <= 1'b0;
    @(posedge sys_clk);
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_regs();
    rd(ADDR_LOOP, 8'h00);
    rd(ADDR_PATTERN_DETECT, 8'h00);
    rd(ADDR_FIRST_STATUS, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(ADDR_PATTERN_DETECT, 8'h08);
    rd(ADDR_PATTERN_DETECT, 8'h08);
    wr(ADDR_PATTERN_DETECT, 8'h00);
  endtask
  task automatic t_analog();
    paths(4'h0, 6'b000000, 4'b0011, 5'b11000, 4'b0000);
    paths(4'h7, 6'b011000, 4'b0011, 5'b00000, 4'b1000);
    paths(4'h1, 6'b011010, 4'b1011, 5'b01000, 4'b1000);
  endtask
  task automatic t_remote();
    paths(4'h2, 6'b110100, 4'b0001, 5'b01111, 4'b0101);
    paths(4'h2, 6'b110101, 4'b1110, 5'b10111, 4'b0101);
    paths(4'h2, 6'b000000, 4'b0011, 5'b01000, 4'b0101);
  endtask
  task automatic t_digital();
    paths(4'h4, 6'b011000, 4'b0011, 5'b00010, 4'b0010);
    paths(4'h4, 6'b011011, 4'b1100, 5'b11010, 4'b0010);
  endtask
  task automatic t_dual();
    paths(4'h6, 6'b110101, 4'b0101, 5'b01111, 4'b0111);
    paths(4'h6, 6'b110000, 4'b0011, 5'b00011, 4'b0111);
    paths(4'h6, 6'b110010, 4'b1000, 5'b01011, 4'b0111);
  endtask
  task automatic t_auto_remote();
    wr(ADDR_PATTERN_DETECT, 8'h00);
    no_auto(4'h0);
    no_auto(4'hc);
    wr(ADDR_LOOP, 8'h08);
    code_run(4'b1000, 1'b1);
    repeat (30) @(posedge sys_clk);
    rd(ADDR_FIRST_STATUS, 8'h82);
    code_run(4'b0100, 1'b0);
    repeat (30) @(posedge sys_clk);
    rd(ADDR_FIRST_STATUS, 8'h00);
    code_run(4'b1000, 1'b1);
    wr(ADDR_LOOP, 8'h00);
    repeat (30) @(posedge sys_clk);
    rd(ADDR_FIRST_STATUS, 8'h00);
    rx_activate_code <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_auto_digital();
    wr(ADDR_PATTERN_DETECT, 8'h08);
    wr(ADDR_LOOP, 8'h08);
    code_run(4'b0010, 1'b1);
    paths(4'ha, 6'b110101, 4'b1111, 5'b00111, 4'b0111);
    rd(ADDR_FIRST_STATUS, 8'h86);
    code_run(4'b0001, 1'b0);
  endtask
  // --------
  // run and verdict
  // --------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_analog();
    t_remote();
    t_digital();
    t_dual();
    t_auto_remote();
    t_auto_digital();
    test_done();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #100us;
    fails++;
    test_done();
  end
endmodule
